// file: common/axis_io_defines.vh
// Purpose: shared constants for the axis motion i/o block
// Assumes: 20 MHz aclk, AXI4-Lite register access
// Notes: offsets are byte addresses
`ifndef AXIS_IO_DEFINES_VH
`define AXIS_IO_DEFINES_VH
// register byte offsets
`define REG_ENABLE 8'h00
`define REG_POLARITY 8'h04
`define REG_CRITERIA 8'h08
`define REG_DELAY 8'h0C
`define REG_RANGE 8'h10
`define REG_POS 8'h14
`define REG_TARGET 8'h18
`define REG_SWLIM_FWD 8'h1C
`define REG_SWLIM_REV 8'h20
`define REG_CMD 8'h24
`define REG_STATUS 8'h28
`define REG_INPUTS 8'h2C
// enable bits
`define EN_FWD_HW 0
`define EN_REV_HW 1
`define EN_FWD_SW 2
`define EN_REV_SW 3
`define EN_HOME 4
`define EN_INHIBIT 5
`define EN_INPOS 6
`define EN_READY 7
`define EN_ALMCLR 8
`define EN_INH_OUT 9
// polarity bits: 1 = active low / active open
`define POL_FWD 0
`define POL_REV 1
`define POL_HOME 2
`define POL_INHIBIT 3
`define POL_INPOS 4
`define POL_READY 5
`define POL_INH_OUT 6
// move-complete criteria bits
`define CRIT_OFF 0
`define CRIT_STOP 1
`define CRIT_DELAY 2
`define CRIT_RANGE 3
`define CRIT_INPOS 4
// command bits (write-one pulses)
`define CMD_START 0
`define CMD_HALT 1
`define CMD_KILL 2
`define CMD_FE_TRIP 3
`define CMD_FAULT_CLR 4
`define CMD_STOPPED 5
`define CMD_MOTOR_ON 6
`define CMD_FIND_REF 7
// reset values
`define ENABLE_RST 10'h000
`define POLARITY_RST 7'h00
`define CRITERIA_RST 5'h02
// timing
`define CLK_HZ 20000000
`define INHIBIT_SAMPLE_US 1000
`define ALMCLR_PULSE_US 10
`endif

// file: design/axis_motion_io.v
// Purpose: per-axis motion input conditioning and move-complete status
// Assumes: one axis; trajectory state supplied through command/position registers
// Notes: AXI4-Lite slave, answers one cycle after both channels are held
`include "axis_io_defines.vh"
module axis_motion_io #(
   parameter INHIBIT_TICKS = `CLK_HZ / 1000000 * `INHIBIT_SAMPLE_US,
   parameter ALMCLR_TICKS = `CLK_HZ / 1000000 * `ALMCLR_PULSE_US
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // motion input pins
   input wire fwd_limit_pin,
   input wire rev_limit_pin,
   input wire home_pin,
   input wire inhibit_in_pin,
   input wire in_position_pin,
   input wire drive_ready_pin,
   // motion outputs
   output reg inhibit_out_pin,
   output reg alarm_clear_pin,
   output reg halt_stop,
   output reg move_running,
   output reg find_ref_run,
   output reg move_done_status_word
);
   localparam [1:0] MD_IDLE = 2'h0;
   localparam [1:0] MD_WAIT = 2'h1;
   localparam [1:0] MD_DELAY = 2'h2;
   localparam [1:0] MD_DONE = 2'h3;

   // =====================================================
   // registers
   reg [9:0] enable_r;
   reg [6:0] polarity_r;
   reg [4:0] criteria_r;
   reg [31:0] delay_r;
   reg [31:0] range_r;
   reg [31:0] pos_r;
   reg [31:0] target_r;
   reg [31:0] swlim_fwd_r;
   reg [31:0] swlim_rev_r;
   reg [7:0] cmd_r;
   reg motor_on_r;
   reg stopped_r;
   reg inhibit_latch_r;
   reg refused_r;
   reg [1:0] md_state_r;
   reg [31:0] delay_cnt_r;
   reg [31:0] almclr_cnt_r;
   reg [5:0] lim_prev_r;
   reg [7:0] awaddr_r;
   reg aw_held_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   reg w_held_r;

   // =====================================================
   // input conditioning
   wire [5:0] in_act;
   wire inhibit_tick;
   wire [5:0] pins;
   wire [5:0] in_pol;
   assign pins = {drive_ready_pin, in_position_pin, inhibit_in_pin, home_pin,
      rev_limit_pin, fwd_limit_pin};
   assign in_pol = {polarity_r[`POL_READY], polarity_r[`POL_INPOS],
      polarity_r[`POL_INHIBIT], polarity_r[`POL_HOME], polarity_r[`POL_REV],
      polarity_r[`POL_FWD]};

   pin_sync #(
      .W(6)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(pins),
      .active_low(in_pol),
      .asserted(in_act)
   );

   tick_div #(
      .PERIOD(INHIBIT_TICKS)
   ) u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(inhibit_tick)
   );

   wire fwd_hw;
   wire rev_hw;
   wire home_act;
   wire in_pos;
   wire fwd_sw;
   wire rev_sw;
   wire limit_any;
   wire limit_rise;
   assign fwd_hw = in_act[0] & enable_r[`EN_FWD_HW];
   assign rev_hw = in_act[1] & enable_r[`EN_REV_HW];
   assign home_act = in_act[2] & enable_r[`EN_HOME];
   assign in_pos = in_act[4] & enable_r[`EN_INPOS];
   assign fwd_sw = enable_r[`EN_FWD_SW] & ($signed(pos_r) >= $signed(swlim_fwd_r));
   assign rev_sw = enable_r[`EN_REV_SW] & ($signed(pos_r) <= $signed(swlim_rev_r));
   assign limit_any = fwd_hw | rev_hw | fwd_sw | rev_sw;
   // limit edges (hw and sw) trigger the halt once; a held limit only blocks
   assign limit_rise = (fwd_hw & ~lim_prev_r[0]) | (rev_hw & ~lim_prev_r[1])
      | (fwd_sw & ~lim_prev_r[2]) | (rev_sw & ~lim_prev_r[3]);

   // =====================================================
   // move-complete criteria
   wire [31:0] diff;
   wire [31:0] abs_diff;
   wire crit_off;
   wire crit_stop;
   wire crit_range;
   wire crit_inpos;
   wire others_met;
   wire start_ok;
   assign diff = pos_r - target_r;
   assign abs_diff = diff[31] ? (~diff + 32'h00000001) : diff;
   assign crit_off = ~criteria_r[`CRIT_OFF] | ~motor_on_r;
   assign crit_stop = ~criteria_r[`CRIT_STOP] | stopped_r;
   assign crit_range = ~criteria_r[`CRIT_RANGE] | (abs_diff < range_r);
   assign crit_inpos = ~criteria_r[`CRIT_INPOS] | in_pos;
   assign others_met = crit_off & crit_stop & crit_range & crit_inpos;
   assign start_ok = cmd_r[`CMD_START] & ~limit_any;

   // =====================================================
   // axi4-lite write path
   wire wr_fire;
   wire [7:0] wa;
   assign wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid;
   assign wa = awaddr_r;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_r <= s_axi_awaddr;
            aw_held_r <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            w_held_r <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wa > `REG_CMD || wa[1:0] != 2'h0) ? 2'h2 : 2'h0;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // byte-lane merge of the held write word into an old value
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] be;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1)
            if (be[k])
               merge[k*8 +: 8] = nw[k*8 +: 8];
      end
   endfunction

   always @(posedge aclk) begin
      if (!aresetn) begin
         enable_r <= `ENABLE_RST;
         polarity_r <= `POLARITY_RST;
         criteria_r <= `CRITERIA_RST;
         delay_r <= 32'h00000000;
         range_r <= 32'h00000000;
         pos_r <= 32'h00000000;
         target_r <= 32'h00000000;
         swlim_fwd_r <= 32'h7FFFFFFF;
         swlim_rev_r <= 32'h80000000;
         cmd_r <= 8'h00;
      end else begin
         cmd_r <= 8'h00;
         if (wr_fire) begin
            case (wa)
               `REG_ENABLE: enable_r <= {wstrb_r[1] ? wdata_r[9:8] : enable_r[9:8],
                  wstrb_r[0] ? wdata_r[7:0] : enable_r[7:0]};
               `REG_POLARITY: polarity_r <= wdata_r[6:0] & {7{wstrb_r[0]}} | polarity_r & ~{7{wstrb_r[0]}};
               `REG_CRITERIA: criteria_r <= wstrb_r[0] ? wdata_r[4:0] : criteria_r;
               `REG_DELAY: delay_r <= merge(delay_r, wdata_r, wstrb_r);
               `REG_RANGE: range_r <= merge(range_r, wdata_r, wstrb_r);
               `REG_POS: pos_r <= merge(pos_r, wdata_r, wstrb_r);
               `REG_TARGET: target_r <= merge(target_r, wdata_r, wstrb_r);
               `REG_SWLIM_FWD: swlim_fwd_r <= merge(swlim_fwd_r, wdata_r, wstrb_r);
               `REG_SWLIM_REV: swlim_rev_r <= merge(swlim_rev_r, wdata_r, wstrb_r);
               `REG_CMD: cmd_r <= wstrb_r[0] ? wdata_r[7:0] : 8'h00;
               default: cmd_r <= 8'h00;
            endcase
         end
      end
   end

   // =====================================================
   // axi4-lite read path
   reg [31:0] rd_word;
   always @* begin
      rd_word = 32'h00000000;
      case (s_axi_araddr)
         `REG_ENABLE: rd_word = {22'h0, enable_r};
         `REG_POLARITY: rd_word = {25'h0, polarity_r};
         `REG_CRITERIA: rd_word = {27'h0, criteria_r};
         `REG_DELAY: rd_word = delay_r;
         `REG_RANGE: rd_word = range_r;
         `REG_POS: rd_word = pos_r;
         `REG_TARGET: rd_word = target_r;
         `REG_SWLIM_FWD: rd_word = swlim_fwd_r;
         `REG_SWLIM_REV: rd_word = swlim_rev_r;
         `REG_STATUS: rd_word = {24'h0, refused_r, find_ref_run, motor_on_r, stopped_r,
            halt_stop, move_running, inhibit_latch_r, move_done_status_word};
         `REG_INPUTS: rd_word = {20'h0, rev_sw, fwd_sw, limit_any, in_pos, in_act, 2'h0};
         default: rd_word = 32'h00000000;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= (s_axi_araddr > `REG_INPUTS || s_axi_araddr[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // =====================================================
   // axis motion state
   always @(posedge aclk) begin
      if (!aresetn) begin
         lim_prev_r <= 6'h00;
         halt_stop <= 1'b0;
         move_running <= 1'b0;
         motor_on_r <= 1'b0;
         stopped_r <= 1'b1;
         refused_r <= 1'b0;
         find_ref_run <= 1'b0;
         inhibit_latch_r <= 1'b0;
         inhibit_out_pin <= 1'b0;
      end else begin
         lim_prev_r <= {2'h0, rev_sw, fwd_sw, rev_hw, fwd_hw};
         halt_stop <= limit_rise | cmd_r[`CMD_HALT];
         if (inhibit_tick)
            inhibit_latch_r <= in_act[3] & enable_r[`EN_INHIBIT];
         if (cmd_r[`CMD_KILL] || cmd_r[`CMD_FE_TRIP])
            motor_on_r <= 1'b0;
         else if (cmd_r[`CMD_MOTOR_ON])
            motor_on_r <= 1'b1;
         if (cmd_r[`CMD_START])
            refused_r <= limit_any;
         if (limit_rise || cmd_r[`CMD_HALT] || cmd_r[`CMD_KILL] || cmd_r[`CMD_STOPPED]) begin
            move_running <= 1'b0;
            stopped_r <= 1'b1;
            find_ref_run <= 1'b0;
         end else if (start_ok) begin
            move_running <= 1'b1;
            stopped_r <= 1'b0;
         end
         if (cmd_r[`CMD_FIND_REF] && enable_r[`EN_FWD_HW] && enable_r[`EN_REV_HW]
               && enable_r[`EN_HOME] && !limit_rise)
            find_ref_run <= 1'b1;
         else if (home_act)
            find_ref_run <= 1'b0;
         inhibit_out_pin <= enable_r[`EN_INH_OUT] & ~motor_on_r ^ polarity_r[`POL_INH_OUT];
      end
   end

   // alarm-clear pulse on fault clear
   always @(posedge aclk) begin
      if (!aresetn) begin
         almclr_cnt_r <= 32'h00000000;
         alarm_clear_pin <= 1'b0;
      end else if (cmd_r[`CMD_FAULT_CLR] && enable_r[`EN_ALMCLR]) begin
         almclr_cnt_r <= ALMCLR_TICKS;
         alarm_clear_pin <= 1'b1;
      end else if (almclr_cnt_r > 32'h00000001) begin
         almclr_cnt_r <= almclr_cnt_r - 32'h00000001;
      end else begin
         almclr_cnt_r <= 32'h00000000;
         alarm_clear_pin <= 1'b0;
      end
   end

   // =====================================================
   // move-complete sequencer
   always @(posedge aclk) begin
      if (!aresetn) begin
         md_state_r <= MD_IDLE;
         delay_cnt_r <= 32'h00000000;
         move_done_status_word <= 1'b1;
      end else if (start_ok) begin
         md_state_r <= MD_WAIT;
         move_done_status_word <= 1'b0;
         delay_cnt_r <= 32'h00000000;
      end else begin
         case (md_state_r)
            MD_IDLE: md_state_r <= MD_WAIT;
            MD_WAIT:
               if (others_met) begin
                  delay_cnt_r <= 32'h00000000;
                  md_state_r <= criteria_r[`CRIT_DELAY] ? MD_DELAY : MD_DONE;
               end
            MD_DELAY:
               if (!others_met)
                  md_state_r <= MD_WAIT;
               else if (delay_cnt_r + 32'h00000001 >= delay_r)
                  md_state_r <= MD_DONE;
               else
                  delay_cnt_r <= delay_cnt_r + 32'h00000001;
            MD_DONE: begin
               move_done_status_word <= others_met;
               if (!others_met)
                  md_state_r <= MD_WAIT;
            end
            default: md_state_r <= MD_IDLE;
         endcase
      end
   end
endmodule

// file: design/pin_sync.v
// Purpose: two-stage synchroniser per pin, then polarity to active-high
// Assumes: pins asynchronous to aclk
// Notes: first stage is read only by the second
module pin_sync #(
   parameter W = 6
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // pins
   input wire [W-1:0] pin,
   input wire [W-1:0] active_low,
   // conditioned
   output reg [W-1:0] asserted
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   genvar i;
   always @(posedge aclk) begin
      if (!aresetn) begin
         s1_r <= {W{1'b0}};
         s2_r <= {W{1'b0}};
      end else begin
         s1_r <= pin;
         s2_r <= s1_r;
      end
   end
   generate
      for (i = 0; i < W; i = i + 1) begin : g_pol
         always @(posedge aclk) begin
            if (!aresetn)
               asserted[i] <= 1'b0;
            else
               asserted[i] <= s2_r[i] ^ active_low[i];
         end
      end
   endgenerate
endmodule

// file: design/tick_div.v
// Purpose: one-cycle enable pulse every PERIOD cycles
// Assumes: PERIOD >= 1
// Notes: used for the 1 ms inhibit-in sampling
module tick_div #(
   parameter PERIOD = 20000
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // tick
   output reg tick
);
   reg [31:0] cnt_r;
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= 32'h00000000;
         tick <= 1'b0;
      end else if (cnt_r == PERIOD - 1) begin
         cnt_r <= 32'h00000000;
         tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 32'h00000001;
         tick <= 1'b0;
      end
   end
endmodule

// file: testbench/axis_motion_io_and_move_complete_tb_top.sv
// Purpose: directed register-level test of the axis motion i/o block
// Assumes: shortened tick parameters; full write strobes
// Notes: pins come from motion_pins_model
`include "axis_io_defines.vh"
module axis_motion_io_and_move_complete_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
   logic [5:0] want, low_active, pins;
   logic alarm_kick, inhibit_out_pin, alarm_clear_pin, halt_stop, move_running;
   logic find_ref_run, move_done_status_word;
   int mismatches, samples_checked, n, i;
   int posv[4] = '{104, 105, 96, 95};
   logic [31:0] modes[3] = '{32'h000, 32'h003, 32'h013};

   axis_motion_io #(.INHIBIT_TICKS(8), .ALMCLR_TICKS(3)) dut (.*, .s_axi_wstrb(4'hF),
      .fwd_limit_pin(pins[0]), .rev_limit_pin(pins[1]), .home_pin(pins[2]),
      .inhibit_in_pin(pins[3]), .in_position_pin(pins[4]), .drive_ready_pin(pins[5]));
   motion_pins_model #(.HOLD(12)) pins_i (.aclk(aclk), .want(want), .low_active(low_active),
      .alarm_kick(alarm_kick), .pins(pins));

   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   // ========================================
   // bus tasks and comparison
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic fail_out;
      mismatches++;
      end_sim();
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int k);
      repeat (k) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      // bready stays up: a drop here would clash with the next call's raise
      wr_resp = s_axi_bresp;
      if (n == 50) fail_out();
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      if (n == 50) fail_out();
   endtask
   // command takes effect a cycle after the response, so settle before looking
   task automatic cmd(input int b, input int k);
      wr(`REG_CMD, 32'h1 << b);
      idle(k);
   endtask
   task automatic wait_hi(ref logic s);
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s === 1'b1) break;
      end
   endtask

   initial begin
      #1_000_000;
      fail_out();
   end

   // ========================================
   // scenarios
   initial begin
      {mismatches, samples_checked} = 0;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
      {want, low_active, alarm_kick} = 0;
      idle(10);
      aresetn <= 1'b1;
      idle(1);
      rd(`REG_CRITERIA);
      chk(rd_data, 32'h00000002);
      rd(`REG_SWLIM_FWD);
      chk(rd_data, 32'h7FFFFFFF);
      rd(8'h3C);
      chk({rd_resp, rd_data[29:0]}, 32'h80000000);
      wr(8'h3C, 32'h00000000);
      chk(wr_resp, 32'h00000002);
      want <= 6'h35;
      for (i = 0; i < 2; i++) begin
         low_active <= i ? 6'h3F : 6'h00;
         wr(`REG_POLARITY, i ? 32'h3F : 32'h00);
         idle(6);
         rd(`REG_INPUTS);
         chk(rd_data[7:2], 6'h35);
      end
      low_active <= 6'h00;
      wr(`REG_POLARITY, 32'h0);
      want <= 6'h03;
      idle(6);
      cmd(`CMD_START, 3);
      chk(move_running, 1);
      cmd(`CMD_HALT, 0);
      wait_hi(halt_stop);
      chk(32'(n < 40), 1);
      want <= 6'h00;
      wr(`REG_ENABLE, 32'h3);
      idle(6);
      cmd(`CMD_START, 3);
      chk(move_running, 1);
      want <= 6'h01;
      wait_hi(halt_stop);
      chk(32'(n < 40), 1);
      idle(3);
      chk(move_running, 0);
      cmd(`CMD_START, 3);
      chk(move_running, 0);
      rd(`REG_STATUS);
      chk(rd_data[7], 1);
      want <= 6'h02;
      idle(6);
      cmd(`CMD_START, 3);
      chk(move_running, 0);
      want <= 6'h00;
      wr(`REG_SWLIM_FWD, 32'd50);
      wr(`REG_POS, 32'd60);
      wr(`REG_ENABLE, 32'h4);
      idle(3);
      cmd(`CMD_START, 3);
      chk(move_running, 0);
      wr(`REG_ENABLE, 32'h0);
      cmd(`CMD_START, 3);
      chk(move_running, 1);
      chk(move_done_status_word, 0);
      cmd(`CMD_STOPPED, 5);
      chk(move_done_status_word, 1);
      wr(`REG_DELAY, 32'd20);
      wr(`REG_CRITERIA, 32'h4);
      cmd(`CMD_START, 0);
      wait_hi(move_done_status_word);
      // n counts whole cycles since the start edge, so the clear time is n
      chk(32'(n >= 20 && n < 40), 1);
      wr(`REG_ENABLE, 32'h200);
      wr(`REG_CRITERIA, 32'h1);
      for (i = 0; i < 2; i++) begin
         cmd(`CMD_MOTOR_ON, 3);
         chk(inhibit_out_pin, 0);
         cmd(`CMD_START, 3);
         chk(move_done_status_word, 0);
         cmd(i ? `CMD_FE_TRIP : `CMD_KILL, 5);
         chk(move_done_status_word, 1);
         chk(inhibit_out_pin, 1);
      end
      wr(`REG_POLARITY, 32'h40);
      idle(2);
      chk(inhibit_out_pin, 0);
      wr(`REG_CRITERIA, 32'h8);
      wr(`REG_RANGE, 32'd5);
      wr(`REG_TARGET, 32'd100);
      for (i = 0; i < 4; i++) begin
         wr(`REG_POS, posv[i]);
         cmd(`CMD_START, 5);
         chk(move_done_status_word, 32'(posv[i] > 95 && posv[i] < 105));
      end
      wr(`REG_ENABLE, 32'h40);
      wr(`REG_CRITERIA, 32'h10);
      cmd(`CMD_START, 5);
      chk(move_done_status_word, 0);
      want <= 6'h10;
      idle(8);
      chk(move_done_status_word, 1);
      want <= 6'h00;
      for (i = 0; i < 2; i++) begin
         wr(`REG_ENABLE, i ? 32'h0 : 32'h100);
         cmd(`CMD_FAULT_CLR, 0);
         wait_hi(alarm_clear_pin);
         chk(32'(n < 40), 32'(i == 0));
      end
      wr(`REG_ENABLE, 32'h20);
      rd(`REG_STATUS);
      chk(rd_data[1], 0);
      alarm_kick <= 1'b1;
      idle(1);
      alarm_kick <= 1'b0;
      // latch is resampled each tick, so look while the stretched alarm is still seen
      idle(13);
      rd(`REG_STATUS);
      chk(rd_data[1], 1);
      idle(30);
      rd(`REG_STATUS);
      chk(rd_data[1], 0);
      for (i = 0; i < 3; i++) begin
         wr(`REG_ENABLE, modes[i]);
         cmd(`CMD_FIND_REF, 4);
         chk(find_ref_run, 32'(i == 2));
      end
      end_sim();
   end
endmodule

// file: testbench/axis_motion_io_checker.sv
// Purpose: port-level assertions for the axis motion i/o block
// Assumes: one aclk domain, synchronous active-low reset
// Notes: attached by bind at the foot of this file
module axis_motion_io_checker #(
   parameter ALMCLR_TICKS = 3
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // bus handshakes
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // motion outputs
   input wire halt_stop,
   input wire move_running,
   input wire alarm_clear_pin,
   input wire move_done_status_word
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   reg [15:0] alarm_len_r;
   // ========================================
   // length of the current alarm-clear pulse
   always @(posedge aclk) begin
      if (!aresetn || !alarm_clear_pin)
         alarm_len_r <= 16'h0000;
      else
         alarm_len_r <= alarm_len_r + 16'h0001;
   end
   // ========================================
   // bus and motion relations
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer missing");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer not held");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer missing");
   write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer not held");
   read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   halt_ends_move_a: assert property (halt_stop |-> ##[0:2] !move_running)
      else $error("move survives halt");
   start_clears_a: assert property (
      $rose(move_running) |-> ##[0:1] !move_done_status_word)
      else $error("done not cleared at start");
   alarm_width_a: assert property (
      $fell(alarm_clear_pin) |-> alarm_len_r == ALMCLR_TICKS)
      else $error("alarm clear pulse width wrong");
endmodule

bind axis_motion_io axis_motion_io_checker #(.ALMCLR_TICKS(ALMCLR_TICKS)) checker_i (.*);

// file: testbench/motion_pins_model.sv
// Purpose: switches, sensors and drive signals of one axis
// Assumes: bit order fwd, rev, home, inhibit, in-position, ready
// Notes: pins are static levels apart from the stretched drive alarm
module motion_pins_model #(
   parameter HOLD = 12
) (
   // clock
   input wire aclk,
   // requested asserted state and pin sense
   input wire [5:0] want,
   input wire [5:0] low_active,
   input wire alarm_kick,
   // pins
   output wire [5:0] pins
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [15:0] alarm_left_r = 16'h0000;
   // alarm held longer than one sampling period so the slow latch sees it
   always @(posedge aclk) begin
      if (alarm_kick)
         alarm_left_r <= 16'(HOLD);
      else if (alarm_left_r != 16'h0000)
         alarm_left_r <= alarm_left_r - 16'h0001;
   end
   assign pins = (want | {2'b00, alarm_left_r != 16'h0000, 3'b000})
      ^ low_active;
endmodule
